// File: src/data_memory_sector_decoder.sv
`timescale 1ns/10ps
`include "dmem_defines.svh"

// Notes on behaviour
// - Data memory holds 8-bit volatile words starting at address zero.
// - Locations 00H-7FH of sector 0 are special registers.
// - Sector 1 implements only 40H, the nonvolatile memory control register.
// - 80H-FFH of sectors 0 and 1 are separate general RAM, 256 bytes.
// - General RAM is freely readable and writable.
// - Indirect access takes its sector from the matching pointer high byte.
// - Indirect access takes its location from the matching pointer low byte.
// - No bank register; sector comes from pointer high byte or extended address.
// - Extended address is 9 bits: top bit sector, low byte location.
// - Standard direct reaches sector 0, extended direct reaches any sector.
// - Bit set and clear change one bit and keep the others.
// - Unimplemented special locations read as zero.
module data_memory_sector_decoder
    import dmem_pkg::*;
#(
    parameter int DW      = `DM_DATA_W,
    parameter int AW      = `DM_ADDR_W,
    parameter int SECTORS = `DM_SECTORS
) (
    // Clock, reset, enable
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // Request from the execution unit
    input  wire logic          req_valid,
    input  wire mode_t         req_mode,
    input  wire op_t           req_op,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    input  wire logic [2:0]    req_bit,
    // Answer
    output logic               rd_valid_r,
    output logic [DW-1:0]      rd_data_r,
    // External special register file
    output logic               sfr_rd_r,
    output logic               sfr_wr_r,
    output logic [7:0]         sfr_addr_r,
    output logic [DW-1:0]      sfr_wdata_r,
    input  wire logic [DW-1:0] sfr_rdata,
    // Held control register
    output logic [DW-1:0]      nvm_control_reg_r
);
    localparam int IW = 8;

    if (DW != 8 || AW != 9 || SECTORS != 2) begin : g_chk
        $error("data_memory_sector_decoder: only 8-bit data, 9-bit address, 2 sectors");
    end

    typedef struct packed {
        // Stage A: request as taken
        logic          a_v;
        mode_t         a_mode;
        op_t           a_op;
        logic [AW-1:0] a_addr;
        logic [DW-1:0] a_wdata;
        logic [2:0]    a_bit;
        // Stage B: decoded, special register read in flight
        logic          b_v;
        logic          b_sfr;
        op_t           b_op;
        logic [DW-1:0] b_wdata;
        logic [2:0]    b_bit;
        logic [DW-1:0] b_res;
        // Outputs
        logic          rd_v;
        logic [DW-1:0] rd_data;
        logic          sfr_rd;
        logic          sfr_wr;
        logic [7:0]    sfr_addr;
        logic [DW-1:0] sfr_wdata;
        logic [DW-1:0] nvm_ctrl;
        // Pointer pairs
        logic [7:0]    indirect_sector_ptr_a;
        logic [7:0]    indirect_offset_ptr_a;
        logic [7:0]    indirect_sector_ptr_b;
        logic [7:0]    indirect_offset_ptr_b;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    gpr_port_if #(.DW(DW), .IW(IW)) gpr ();

    gpr_store #(
        .DW    (DW),
        .DEPTH (SECTORS * `DM_GPR_PER_SECTOR),
        .IW    (IW)
    ) u_store (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .port  (gpr.store)
    );

    // Result byte of an operation on an old value
    function automatic logic [DW-1:0] apply_op(
        input op_t           op,
        input logic [DW-1:0] old,
        input logic [DW-1:0] wd,
        input logic [2:0]    bsel
    );
        logic [DW-1:0] mask;
        mask = DW'(1) << bsel;
        unique case (op)
            OP_READ:  apply_op = old;
            OP_WRITE: apply_op = wd;
            OP_BSET:  apply_op = old | mask;
            OP_BCLR:  apply_op = old & ~mask;
        endcase
    endfunction : apply_op

    // Where a sector/location pair lands
    function automatic tgt_t decode(input logic [7:0] sec, input logic [7:0] off);
        if (sec >= 8'(SECTORS)) begin
            decode = TGT_NONE;
        end else if (off >= `DM_GPR_FIRST) begin
            decode = TGT_RAM;
        end else if (sec == 8'h00) begin
            if (off == `DM_PTR_A_LO_ADDR || off == `DM_PTR_A_HI_ADDR ||
                off == `DM_PTR_B_LO_ADDR || off == `DM_PTR_B_HI_ADDR) begin
                decode = TGT_LOCAL;
            end else begin
                decode = TGT_SFR;
            end
        end else if (off == `DM_NVM_CTRL_ADDR) begin
            decode = TGT_LOCAL;
        end else begin
            decode = TGT_NONE;
        end
    endfunction : decode

    logic [7:0]    sec;
    logic [7:0]    off;
    tgt_t          tgt;
    logic [DW-1:0] local_old;
    logic [DW-1:0] a_res;
    logic          a_writes;

    always_comb begin
        // no bank register; sector only from the mode below
        unique case (s_r.a_mode)
            MD_DIRECT: begin
                sec = 8'h00;
                off = s_r.a_addr[7:0];
            end
            MD_EXTENDED: begin
                sec = {7'h00, s_r.a_addr[8]};
                off = s_r.a_addr[7:0];
            end
            MD_IND_A: begin
                sec = s_r.indirect_sector_ptr_a;
                off = s_r.indirect_offset_ptr_a;
            end
            MD_IND_B: begin
                sec = s_r.indirect_sector_ptr_b;
                off = s_r.indirect_offset_ptr_b;
            end
        endcase
        tgt = decode(sec, off);
        a_writes = s_r.a_v && (s_r.a_op != OP_READ);

        local_old = `DM_UNIMPL_READ;
        if (sec == 8'h00) begin
            unique case (off)
                `DM_PTR_A_LO_ADDR: local_old = s_r.indirect_offset_ptr_a;
                `DM_PTR_A_HI_ADDR: local_old = s_r.indirect_sector_ptr_a;
                `DM_PTR_B_LO_ADDR: local_old = s_r.indirect_offset_ptr_b;
                `DM_PTR_B_HI_ADDR: local_old = s_r.indirect_sector_ptr_b;
                default:           local_old = `DM_UNIMPL_READ;
            endcase
        end else begin
            local_old = s_r.nvm_ctrl;
        end

        // Sector bit above the 7-bit location gives a distinct store per sector
        gpr.idx   = {sec[0], off[6:0]};
        gpr.wdata = apply_op(s_r.a_op, gpr.rdata, s_r.a_wdata, s_r.a_bit);
        gpr.we    = a_writes && (tgt == TGT_RAM);

        unique case (tgt)
            TGT_RAM:   a_res = gpr.wdata;
            TGT_LOCAL: a_res = apply_op(s_r.a_op, local_old, s_r.a_wdata, s_r.a_bit);
            TGT_SFR:   a_res = `DM_UNIMPL_READ;
            TGT_NONE:  a_res = `DM_UNIMPL_READ;
        endcase

        s_nxt = s_r;

        // Stage A
        s_nxt.a_v     = req_valid;
        s_nxt.a_mode  = req_mode;
        s_nxt.a_op    = req_op;
        s_nxt.a_addr  = req_addr;
        s_nxt.a_wdata = req_wdata;
        s_nxt.a_bit   = req_bit;

        // Pointer and control writes land here, so the very next request
        // already decodes through the updated pointer
        if (a_writes && tgt == TGT_LOCAL) begin
            if (sec == 8'h00) begin
                unique case (off)
                    `DM_PTR_A_LO_ADDR: s_nxt.indirect_offset_ptr_a = a_res;
                    `DM_PTR_A_HI_ADDR: s_nxt.indirect_sector_ptr_a = a_res;
                    `DM_PTR_B_LO_ADDR: s_nxt.indirect_offset_ptr_b = a_res;
                    `DM_PTR_B_HI_ADDR: s_nxt.indirect_sector_ptr_b = a_res;
                    default: ;
                endcase
            end else begin
                s_nxt.nvm_ctrl = a_res;
            end
        end

        // Stage B
        s_nxt.b_v      = s_r.a_v;
        s_nxt.b_sfr    = s_r.a_v && (tgt == TGT_SFR);
        s_nxt.b_op     = s_r.a_op;
        s_nxt.b_wdata  = s_r.a_wdata;
        s_nxt.b_bit    = s_r.a_bit;
        s_nxt.b_res    = a_res;
        s_nxt.sfr_rd   = s_r.a_v && (tgt == TGT_SFR);
        // Address holds into the write-back cycle; one address for both strobes,
        // so two special register accesses need a one-cycle gap between them
        if (s_r.a_v && tgt == TGT_SFR) begin
            s_nxt.sfr_addr = off;
        end

        // Stage C: special registers use a read-modify-write through the port
        s_nxt.rd_v      = s_r.b_v;
        s_nxt.rd_data   = s_r.b_sfr ?
                          apply_op(s_r.b_op, sfr_rdata, s_r.b_wdata, s_r.b_bit) :
                          s_r.b_res;
        s_nxt.sfr_wr    = s_r.b_sfr && (s_r.b_op != OP_READ);
        s_nxt.sfr_wdata = apply_op(s_r.b_op, sfr_rdata, s_r.b_wdata, s_r.b_bit);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.nvm_ctrl <= `DM_NVM_CTRL_RST;
            s_r.indirect_sector_ptr_a <= `DM_PTR_RST;
            s_r.indirect_offset_ptr_a <= `DM_PTR_RST;
            s_r.indirect_sector_ptr_b <= `DM_PTR_RST;
            s_r.indirect_offset_ptr_b <= `DM_PTR_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rd_valid_r        = s_r.rd_v;
    assign rd_data_r         = s_r.rd_data;
    assign sfr_rd_r          = s_r.sfr_rd;
    assign sfr_wr_r          = s_r.sfr_wr;
    assign sfr_addr_r        = s_r.sfr_addr;
    assign sfr_wdata_r       = s_r.sfr_wdata;
    assign nvm_control_reg_r = s_r.nvm_ctrl;
endmodule : data_memory_sector_decoder

// File: src/dmem_defines.svh
`ifndef DMEM_DEFINES_SVH
`define DMEM_DEFINES_SVH

// Data path and address widths
`define DM_DATA_W          8
`define DM_ADDR_W          9
`define DM_SECTORS         2
`define DM_GPR_PER_SECTOR  128

// Location map inside one sector
`define DM_SFR_LAST        8'h7f
`define DM_GPR_FIRST       8'h80
`define DM_PTR_A_LO_ADDR   8'h03
`define DM_PTR_A_HI_ADDR   8'h04
`define DM_PTR_B_LO_ADDR   8'h0d
`define DM_PTR_B_HI_ADDR   8'h0e
`define DM_NVM_CTRL_ADDR   8'h40

// Reset and fixed read values
`define DM_PTR_RST         8'h00
`define DM_NVM_CTRL_RST    8'h00
`define DM_UNIMPL_READ     8'h00

// Cycles from the taking edge to the answer
`define DM_ANSWER_LAT      2

`endif

// File: src/dmem_pkg.sv
package dmem_pkg;

    typedef enum logic [1:0] {
        MD_DIRECT   = 2'b00,
        MD_EXTENDED = 2'b01,
        MD_IND_A    = 2'b10,
        MD_IND_B    = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_WRITE = 2'b01,
        OP_BSET  = 2'b10,
        OP_BCLR  = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        TGT_RAM   = 2'b00,
        TGT_SFR   = 2'b01,
        TGT_LOCAL = 2'b10,
        TGT_NONE  = 2'b11
    } tgt_t;

endpackage : dmem_pkg

// File: src/gpr_port_if.sv
`timescale 1ns/10ps
interface gpr_port_if #(
    parameter int DW = 8,
    parameter int IW = 8
);
    logic          we;
    logic [IW-1:0] idx;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport owner (output we, output idx, output wdata, input rdata);
    modport store (input we, input idx, input wdata, output rdata);
endinterface : gpr_port_if

// File: src/gpr_store.sv
`timescale 1ns/10ps
module gpr_store #(
    parameter int DW    = 8,
    parameter int DEPTH = 256,
    parameter int IW    = 8
) (
    // Clock, reset, enable
    input  wire logic   mclk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    // Access port
    gpr_port_if.store   port
);
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
    } store_t;

    store_t s_r;
    store_t s_nxt;

    if (DEPTH != (1 << IW)) begin : g_chk
        $error("gpr_store: DEPTH must equal 2**IW");
    end

    // Read is combinational so the owner can modify and write back in one cycle
    assign port.rdata = s_r.mem[port.idx];

    always_comb begin
        s_nxt = s_r;
        if (port.we) begin
            s_nxt.mem[port.idx] = port.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end
endmodule : gpr_store

// File: test/data_memory_sector_decoder_test.sv
`timescale 1ns/10ps
`include "dmem_defines.svh"
`define CHECK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module data_memory_sector_decoder_test
    import dmem_pkg::*;
;
    logic       mclk, rst_n, ce, req_valid, rd_valid_r, sfr_rd_r, sfr_wr_r;
    mode_t      req_mode;
    op_t        req_op;
    logic [8:0] req_addr;
    logic [7:0] req_wdata, rd_data_r, sfr_addr_r, sfr_wdata_r, sfr_rdata, nvm;
    logic [2:0] req_bit;
    logic [7:0] d;
    int         errors, check_count;

    data_memory_sector_decoder u_data_memory_sector_decoder (.mclk(mclk), .rst_n(rst_n),
        .ce(ce), .req_valid(req_valid), .req_mode(req_mode), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_bit(req_bit),
        .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .sfr_rd_r(sfr_rd_r),
        .sfr_wr_r(sfr_wr_r), .sfr_addr_r(sfr_addr_r), .sfr_wdata_r(sfr_wdata_r),
        .sfr_rdata(sfr_rdata), .nvm_control_reg_r(nvm));
    sfr_file_model u_sfr_file_model (.mclk(mclk), .sfr_rd_r(sfr_rd_r), .sfr_wr_r(sfr_wr_r),
        .sfr_addr_r(sfr_addr_r), .sfr_wdata_r(sfr_wdata_r), .sfr_rdata(sfr_rdata));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic xfer(input mode_t m, input op_t o, input logic [8:0] a,
                        input logic [7:0] wd, input logic [2:0] b);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_mode = m;
        req_op = o;
        req_addr = a;
        req_wdata = wd;
        req_bit = b;
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        // Address dropped once taken, so the write-back may not lean on it
        req_addr = 9'h000;
        while (rd_valid_r !== 1'b1 && n < 8) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHECK("answer", 1'b1, rd_valid_r)
        `CHECK("latency", `DM_ANSWER_LAT, n)
        d = rd_data_r;
    endtask : xfer

    task automatic t_ram;
        xfer(MD_DIRECT, OP_READ, 9'h0ff, 8'h00, 3'h0);
        `CHECK("ram reset", 8'h00, d)
        xfer(MD_DIRECT, OP_WRITE, 9'h085, 8'ha5, 3'h0);
        xfer(MD_EXTENDED, OP_WRITE, 9'h185, 8'h3c, 3'h0);
        xfer(MD_EXTENDED, OP_READ, 9'h085, 8'h00, 3'h0);
        `CHECK("ext sector 0", 8'ha5, d)
        xfer(MD_EXTENDED, OP_READ, 9'h185, 8'h00, 3'h0);
        `CHECK("ext sector 1", 8'h3c, d)
        xfer(MD_DIRECT, OP_READ, 9'h185, 8'h00, 3'h0);
        `CHECK("direct sector 0", 8'ha5, d)
    endtask : t_ram

    task automatic t_indirect;
        xfer(MD_DIRECT, OP_WRITE, 9'h003, 8'h85, 3'h0);
        xfer(MD_DIRECT, OP_WRITE, 9'h004, 8'h01, 3'h0);
        xfer(MD_IND_A, OP_READ, 9'h000, 8'h00, 3'h0);
        `CHECK("ptr a", 8'h3c, d)
        xfer(MD_DIRECT, OP_WRITE, 9'h00d, 8'h85, 3'h0);
        xfer(MD_DIRECT, OP_WRITE, 9'h00e, 8'h00, 3'h0);
        xfer(MD_IND_B, OP_READ, 9'h1ff, 8'h00, 3'h0);
        `CHECK("ptr b", 8'ha5, d)
        xfer(MD_DIRECT, OP_WRITE, 9'h004, 8'h02, 3'h0);
        xfer(MD_IND_A, OP_READ, 9'h000, 8'h00, 3'h0);
        `CHECK("no sector 2", 8'h00, d)
    endtask : t_indirect

    task automatic t_bits_sfr;
        xfer(MD_EXTENDED, OP_WRITE, 9'h190, 8'h0f, 3'h0);
        xfer(MD_EXTENDED, OP_BSET, 9'h190, 8'h00, 3'h7);
        xfer(MD_EXTENDED, OP_BCLR, 9'h190, 8'h00, 3'h0);
        xfer(MD_EXTENDED, OP_READ, 9'h190, 8'h00, 3'h0);
        `CHECK("ram bits", 8'h8e, d)
        xfer(MD_DIRECT, OP_WRITE, 9'h014, 8'h50, 3'h0);
        xfer(MD_DIRECT, OP_BSET, 9'h014, 8'h00, 3'h1);
        xfer(MD_DIRECT, OP_BCLR, 9'h014, 8'h00, 3'h4);
        xfer(MD_DIRECT, OP_READ, 9'h014, 8'h00, 3'h0);
        `CHECK("sfr bits", 8'h42, d)
        xfer(MD_EXTENDED, OP_WRITE, 9'h140, 8'h5a, 3'h0);
        `CHECK("nvm reg", 8'h5a, nvm)
        xfer(MD_EXTENDED, OP_READ, 9'h140, 8'h00, 3'h0);
        `CHECK("nvm read", 8'h5a, d)
        xfer(MD_EXTENDED, OP_READ, 9'h114, 8'h00, 3'h0);
        `CHECK("unused", 8'h00, d)
    endtask : t_bits_sfr

    // A request offered while the enable is low must leave no trace
    task automatic t_freeze;
        @(posedge mclk);
        #1;
        ce = 1'b0;
        req_valid = 1'b1;
        req_mode = MD_DIRECT;
        req_op = OP_WRITE;
        req_addr = 9'h090;
        req_wdata = 8'h77;
        repeat (4) @(posedge mclk);
        #1;
        `CHECK("frozen answer", 1'b0, rd_valid_r)
        ce = 1'b1;
        xfer(MD_DIRECT, OP_READ, 9'h090, 8'h00, 3'h0);
        `CHECK("frozen write", 8'h00, d)
    endtask : t_freeze

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (4000) @(posedge mclk);
        errors++;
        finish_test();
    end

    initial begin
        {rst_n, req_valid, req_wdata, req_bit} = '0;
        ce = 1'b1;
        req_mode = MD_DIRECT;
        req_op = OP_READ;
        req_addr = 9'h000;
        repeat (20) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_ram();
        t_indirect();
        t_bits_sfr();
        t_freeze();
        finish_test();
    end
endmodule : data_memory_sector_decoder_test

bind data_memory_sector_decoder dmem_monitor u_dmem_monitor (.mclk(mclk), .rst_n(rst_n),
    .ce(ce), .req_valid(req_valid), .req_mode(req_mode), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_bit(req_bit),
    .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .sfr_rd_r(sfr_rd_r),
    .sfr_wr_r(sfr_wr_r), .sfr_addr_r(sfr_addr_r), .sfr_wdata_r(sfr_wdata_r),
    .sfr_rdata(sfr_rdata), .nvm_control_reg_r(nvm_control_reg_r));

// File: test/dmem_monitor.sv
`timescale 1ns/10ps
module dmem_monitor
    import dmem_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       ce,
    // Request
    input wire logic       req_valid,
    input wire mode_t      req_mode,
    input wire op_t        req_op,
    input wire logic [8:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [2:0] req_bit,
    // Answer and special register side
    input wire logic       rd_valid_r,
    input wire logic [7:0] rd_data_r,
    input wire logic       sfr_rd_r,
    input wire logic       sfr_wr_r,
    input wire logic [7:0] sfr_addr_r,
    input wire logic [7:0] sfr_wdata_r,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] nvm_control_reg_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic tk;
    logic dsfr;
    logic ext1;
    assign tk = req_valid && ce;
    assign ext1 = tk && req_mode == MD_EXTENDED && req_addr[8];
    // Pointer bytes stay inside, so they never reach the outside file
    assign dsfr = tk && req_mode == MD_DIRECT && !req_addr[7]
        && !(req_addr[7:0] inside {8'h03, 8'h04, 8'h0d, 8'h0e});

    property p_lat; tk |-> ##3 rd_valid_r; endproperty
    a_lat: assert property (p_lat) else $error("answer late or missing");
    property p_sfr_rd;
        dsfr && req_op != OP_WRITE |-> ##2 sfr_rd_r && sfr_addr_r == $past(req_addr[7:0], 2);
    endproperty
    a_sfr_rd: assert property (p_sfr_rd) else $error("special read not issued");
    property p_sfr_data; dsfr && req_op == OP_READ |-> ##3 rd_data_r == $past(sfr_rdata);
    endproperty
    a_sfr_data: assert property (p_sfr_data) else $error("special read data wrong");
    property p_bset; dsfr && req_op == OP_BSET |-> ##3 sfr_wr_r
        && sfr_addr_r == $past(req_addr[7:0], 3)
        && sfr_wdata_r == ($past(sfr_rdata) | (8'h01 << $past(req_bit, 3)));
    endproperty
    a_bset: assert property (p_bset) else $error("bit set result wrong");
    property p_bclr; dsfr && req_op == OP_BCLR |-> ##3 sfr_wr_r
        && sfr_addr_r == $past(req_addr[7:0], 3)
        && sfr_wdata_r == ($past(sfr_rdata) & ~(8'h01 << $past(req_bit, 3)));
    endproperty
    a_bclr: assert property (p_bclr) else $error("bit clear result wrong");
    property p_ram; tk && !req_mode[1] && req_addr[7] |-> ##2 !sfr_rd_r ##1 !sfr_wr_r;
    endproperty
    a_ram: assert property (p_ram) else $error("general RAM access leaked out");
    property p_sec1; ext1 |-> ##2 !sfr_rd_r ##1 !sfr_wr_r; endproperty
    a_sec1: assert property (p_sec1) else $error("sector 1 access leaked out");
    property p_nvm; ext1 && req_addr[7:0] == 8'h40 && req_op == OP_WRITE
        |-> ##2 nvm_control_reg_r == $past(req_wdata, 2);
    endproperty
    a_nvm: assert property (p_nvm) else $error("control register not written");
    property p_zero; ext1 && !req_addr[7] && req_addr[7:0] != 8'h40 && req_op == OP_READ
        |-> ##3 rd_data_r == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("unused location not zero");

    c_bset: cover property (dsfr && req_op == OP_BSET);
    c_ind: cover property (tk && req_mode == MD_IND_B);
    c_nvm: cover property (ext1 && req_addr[7:0] == 8'h40);
endmodule : dmem_monitor

// File: test/sfr_file_model.sv
`timescale 1ns/10ps
module sfr_file_model (
    // Clock
    input wire logic  mclk,
    // Strobes from the decoder
    input wire logic       sfr_rd_r,
    input wire logic       sfr_wr_r,
    input wire logic [7:0] sfr_addr_r,
    input wire logic [7:0] sfr_wdata_r,
    // Read data back
    output logic [7:0]     sfr_rdata
);
    logic [7:0] mem [128];
    logic [7:0] last;
    initial last = 8'h00;
    always @(posedge mclk) begin
        if (sfr_wr_r) begin
            mem[sfr_addr_r[6:0]] <= sfr_wdata_r;
        end
        last <= ~last;
    end
    // Idle data keeps toggling so a sample outside the strobe cannot pass by luck
    always_comb begin
        if (!sfr_rd_r) begin
            sfr_rdata = last;
        end else if (sfr_wr_r) begin
            // Back-to-back on one location: hand over the byte being written
            sfr_rdata = sfr_wdata_r;
        end else begin
            sfr_rdata = mem[sfr_addr_r[6:0]];
        end
    end
endmodule : sfr_file_model
